// [verilog/ccsp_defs.svh]
// Constants shared by both ends of the card coupler serial port
`ifndef CCSP_DEFS_SVH
`define CCSP_DEFS_SVH
// Clock and link timing
`define CCSP_CLK_PERIOD_NS 100
`define CCSP_LINK_PERIOD_NS 800
`define CCSP_HALF_DIV (`CCSP_LINK_PERIOD_NS / `CCSP_CLK_PERIOD_NS / 2)
// Command byte fields
`define CCSP_ADDR_MSB 7
`define CCSP_ADDR_LSB 5
`define CCSP_SUP_MSB 1
`define CCSP_SUP_LSB 0
`define CCSP_ADDR_ALL 3'h5
`define CCSP_BITS_PER_BYTE 4'h8
`define CCSP_ADDR_BITS 3'h3
// Status byte fields
`define CCSP_ST_PRESENT 4
`define CCSP_ST_IO 3
`define CCSP_ST_IRQ 2
// Reset values
`define CCSP_SYNC_RST 8'h02
`define CCSP_CMD_RST 8'h00
`define CCSP_SUP_RST 2'h0
`define CCSP_CTRL_RST 2'h0
// Host register offsets and fields
`define CCSP_REG_TX 2'h0
`define CCSP_REG_CTRL 2'h1
`define CCSP_REG_STATUS 2'h2
`define CCSP_REG_RX 2'h3
`define CCSP_CTRL_HOLD 0
`define CCSP_CTRL_IDLE_HIGH 1
`endif

// [verilog/ccsp_pkg.sv]
// Types shared by both ends of the card coupler serial port
`default_nettype none
package ccsp_pkg;
	typedef logic [7:0] ccsp_byte_t;
	typedef logic [2:0] ccsp_addr_t;
	typedef logic [1:0] ccsp_sup_t;
	typedef enum logic [2:0] {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_GAP, H_END} ccsp_hstate_t;
endpackage
`default_nettype wire

// [verilog/ccsp_if.sv]
// Serial link and interrupt line between host and coupler
`default_nettype none
interface ccsp_if;
	logic spi_clk; // Serial clock from host
	logic cs_n; // Chip select, active low
	logic mosi; // Command data from host
	logic miso; // Status data from coupler
	logic miso_oe; // Coupler drives miso while high
	logic miso_line; // Resolved line, pulled high when undriven
	logic irq_n; // Interrupt, active low
	assign miso_line = miso_oe ? miso : 1'b1;
	modport device (input spi_clk, input cs_n, input mosi, output miso, output miso_oe,
		output irq_n);
	modport host (output spi_clk, output cs_n, output mosi, input miso_line, input irq_n);
endinterface
`default_nettype wire

// [verilog/ccsp_device.sv]
// Coupler end: serial slave command port and interrupt logic
// Operation
// - Interrupt output high after reset
// - Insertion, extraction or supply fault pulls interrupt
// - Interrupt never gated by select or address
// - Clear only in addressed write, address 0xx/101
// - Non-zero supply write acknowledges insertion
// - Zero supply write clears extraction
// - Overload forces supply zero, zero write clears
// - Pending interrupt stays low without release
// - Host polls status to find interrupt source
// - Slave only, either clock idle level
// - Host drives clock, select, mosi; device miso
// - Write-only command, read-only status registers
// - Select high ignores all serial activity
// - Select fall clears shifter, restarts framing
// - Bit valid at fall, shifted at rise
// - MSB first, first three bits are address
// - Address matched against aux contact straps
// - Full byte latched at select rise
// - Several bytes per frame, each decoded alone
// - Host leaves half period between byte bursts
// - Status bit 4 high when card present
// - Status bit 3 mirrors card data line
`include "ccsp_defs.svh"
`default_nettype none
module ccsp_device #(
	parameter bit DETECT_ACTIVE_HIGH = 1'b1
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	ccsp_if.device link,
	input wire logic card_presence_switch_i,
	input wire logic supply_fault_i,
	input wire logic card_io_level_i,
	input wire logic aux_contact_low_i,
	input wire logic aux_contact_high_i,
	output logic irq_n_o,
	output var ccsp_pkg::ccsp_byte_t host_command_register_o,
	output logic cmd_update_o,
	output var ccsp_pkg::ccsp_sup_t card_supply_output_o,
	output logic card_present_o
);
	import ccsp_pkg::*;

	logic [7:0] async_in; // Every input from outside this clock
	logic [7:0] meta; // First synchroniser stage, read only by sync
	logic [7:0] sync; // Second synchroniser stage
	logic sclk_q; // Previous serial clock level
	logic csn_q; // Previous select level
	logic fault_q; // Previous fault level
	ccsp_byte_t shreg; // Input shift register
	logic [2:0] bitcnt; // Bits taken in the current byte
	logic matched; // Current byte addresses this chip
	ccsp_byte_t pend; // Last complete byte for this chip
	logic pend_valid; // A byte waits for select rise
	logic apply; // Pending byte takes effect this cycle
	logic flag_ins; // Insertion pending
	logic flag_ext; // Extraction pending
	logic flag_ov; // Overload pending
	logic miso_q; // Status bit on the line
	logic miso_oe_q; // Line driven
	logic irq_q; // Interrupt level, active low
	ccsp_byte_t status; // Read-back status byte
	logic present; // Card present, polarity removed
	logic sclk_s, csn_s, mosi_s, io_s;
	logic sclk_rise, sclk_fall, cs_fall, cs_rise;
	logic ins_ev, ext_ev, ov_ev;
	ccsp_sup_t wr_sup; // Supply field of the applied byte

	// Chip hit: local address from straps, or the shared code
	function automatic logic chip_hit(input ccsp_addr_t a, input logic [1:0] strap);
		chip_hit = (a[2] == 1'b0 && a[1:0] == strap) || a == `CCSP_ADDR_ALL;
	endfunction

	assign async_in = {aux_contact_high_i, aux_contact_low_i, card_io_level_i,
		supply_fault_i, card_presence_switch_i, link.mosi, link.cs_n, link.spi_clk};

	// Two-stage synchronisers for every pin
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			meta <= `CCSP_SYNC_RST;
			sync <= `CCSP_SYNC_RST;
		end else begin
			meta <= async_in;
			sync <= meta;
		end
	end

	assign sclk_s = sync[0];
	assign csn_s = sync[1];
	assign mosi_s = sync[2];
	assign io_s = sync[5];
	// Both edges found, so either idle level works
	assign sclk_rise = sclk_s & ~sclk_q;
	assign sclk_fall = ~sclk_s & sclk_q;
	assign cs_fall = ~csn_s & csn_q;
	assign cs_rise = csn_s & ~csn_q;
	assign present = DETECT_ACTIVE_HIGH ? sync[3] : ~sync[3];
	assign ins_ev = present & ~card_present_o;
	assign ext_ev = ~present & card_present_o;
	assign ov_ev = sync[4] & ~fault_q;
	assign apply = cs_rise & pend_valid;
	assign wr_sup = pend[`CCSP_SUP_MSB:`CCSP_SUP_LSB];

	// Edge history
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			sclk_q <= 1'b0;
			csn_q <= 1'b1;
			fault_q <= 1'b0;
			card_present_o <= 1'b0;
		end else begin
			sclk_q <= sclk_s;
			csn_q <= csn_s;
			fault_q <= sync[4];
			card_present_o <= present;
		end
	end

	// Byte framing and on-the-fly address decode
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			shreg <= '0;
			bitcnt <= '0;
			matched <= 1'b0;
			pend <= `CCSP_CMD_RST;
			pend_valid <= 1'b0;
		end else if (cs_fall) begin
			// Fresh frame, nothing left from the last one
			shreg <= '0;
			bitcnt <= '0;
			matched <= 1'b0;
			pend_valid <= 1'b0;
		end else if (!csn_s && sclk_rise) begin
			// Shift on rising edge, MSB first
			shreg <= {shreg[6:0], mosi_s};
			if (bitcnt == 3'(`CCSP_ADDR_BITS - 3'h1)) begin
				matched <= chip_hit({shreg[1:0], mosi_s},
					{sync[7], sync[6]});
			end
			if (bitcnt == 3'(`CCSP_BITS_PER_BYTE - 4'h1)) begin
				// Byte done; the next one is decoded on its own
				bitcnt <= '0;
				matched <= 1'b0;
				if (matched) begin
					pend <= {shreg[6:0], mosi_s};
					pend_valid <= 1'b1;
				end
			end else begin
				bitcnt <= bitcnt + 3'h1;
			end
		end else if (apply) begin
			pend_valid <= 1'b0;
		end
	end

	// Command register; a partial last byte is dropped on purpose
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			host_command_register_o <= `CCSP_CMD_RST;
			cmd_update_o <= 1'b0;
		end else begin
			cmd_update_o <= apply;
			if (apply) begin
				host_command_register_o <= pend;
			end
		end
	end

	// Card supply; overload wins over a write in the same cycle
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			card_supply_output_o <= `CCSP_SUP_RST;
		end else if (ov_ev) begin
			card_supply_output_o <= `CCSP_SUP_RST;
		end else if (apply) begin
			card_supply_output_o <= wr_sup;
		end
	end

	// Sticky sources; a new event beats a clear in the same cycle
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			flag_ins <= 1'b0;
			flag_ext <= 1'b0;
			flag_ov <= 1'b0;
		end else begin
			if (ins_ev) begin
				flag_ins <= 1'b1;
			end else if (apply && wr_sup != 2'h0) begin
				flag_ins <= 1'b0;
			end
			if (ext_ev) begin
				flag_ext <= 1'b1;
			end else if (apply && wr_sup == 2'h0) begin
				flag_ext <= 1'b0;
			end
			if (ov_ev) begin
				flag_ov <= 1'b1;
			end else if (apply && wr_sup == 2'h0) begin
				flag_ov <= 1'b0;
			end
		end
	end

	// Interrupt level ignores select and address entirely
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			irq_q <= 1'b1;
		end else begin
			irq_q <= ~(flag_ins | flag_ext | flag_ov);
		end
	end

	assign status = {3'h0, card_present_o, io_s, ~irq_q, card_supply_output_o};

	// Status out on falling edges, only after an address match
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			miso_q <= 1'b1;
			miso_oe_q <= 1'b0;
		end else if (csn_s) begin
			miso_oe_q <= 1'b0;
		end else if (sclk_fall) begin
			if (matched && bitcnt >= `CCSP_ADDR_BITS) begin
				miso_oe_q <= 1'b1;
				miso_q <= status[3'h7 - bitcnt];
			end else begin
				miso_oe_q <= 1'b0;
			end
		end
	end

	assign link.miso = miso_q;
	assign link.miso_oe = miso_oe_q;
	assign link.irq_n = irq_q;
	assign irq_n_o = irq_q;
endmodule
`default_nettype wire

// [verilog/ccsp_host.sv]
// Host end: serial bus master driven through a small register port
`include "ccsp_defs.svh"
`default_nettype none
module ccsp_host #(
	parameter int HALF_DIV = `CCSP_HALF_DIV
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	ccsp_if.host link,
	input wire logic [1:0] addr_i,
	input wire ccsp_pkg::ccsp_byte_t wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output var ccsp_pkg::ccsp_byte_t rdata_o
);
	import ccsp_pkg::*;

	ccsp_hstate_t state; // Transfer sequencer
	logic [7:0] cnt; // Half-period down counter
	logic [2:0] bitn; // Bit being sent
	ccsp_byte_t tx; // Outgoing shift register
	ccsp_byte_t rx; // Captured status byte
	logic [1:0] ctrl; // Hold-frame and idle-level bits
	logic [1:0] meta, sync; // Synchronisers for miso and interrupt
	logic sclk, csn, mosi;
	logic tick;
	logic busy;

	assign tick = cnt == 8'h00;
	assign busy = state != H_IDLE;

	// Miso and interrupt come from another clock domain
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			meta <= 2'h3;
			sync <= 2'h3;
		end else begin
			meta <= {link.irq_n, link.miso_line};
			sync <= meta;
		end
	end

	// Control register
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			ctrl <= `CCSP_CTRL_RST;
		end else if (wr_i && addr_i == `CCSP_REG_CTRL) begin
			ctrl <= wdata_i[1:0];
		end
	end

	// Read port: data only in the cycle after the strobe
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i || !rd_i) begin
			rdata_o <= '0;
		end else begin
			unique case (addr_i)
				`CCSP_REG_TX: rdata_o <= tx;
				`CCSP_REG_CTRL: rdata_o <= {6'h00, ctrl};
				`CCSP_REG_STATUS: rdata_o <= {5'h00, ~sync[1], ~csn, busy};
				`CCSP_REG_RX: rdata_o <= rx;
			endcase
		end
	end

	// Sequencer; a write to the TX register while busy is ignored
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			state <= H_IDLE;
			cnt <= '0;
			bitn <= '0;
			tx <= '0;
			rx <= '0;
			sclk <= 1'b0;
			csn <= 1'b1;
			mosi <= 1'b0;
		end else begin
			cnt <= tick ? 8'(HALF_DIV - 1) : cnt - 8'h01;
			unique case (state)
				H_IDLE: begin
					cnt <= 8'(HALF_DIV - 1);
					sclk <= ctrl[`CCSP_CTRL_IDLE_HIGH];
					if (wr_i && addr_i == `CCSP_REG_TX) begin
						tx <= wdata_i;
						bitn <= '0;
						csn <= 1'b0;
						if (csn) begin
							state <= H_SETUP;
						end else begin
							// Frame already open: go straight to bit 7
							sclk <= 1'b0;
							mosi <= wdata_i[7];
							state <= H_LOW;
						end
					end else if (wr_i && addr_i == `CCSP_REG_CTRL && !csn
						&& !wdata_i[`CCSP_CTRL_HOLD]) begin
						csn <= 1'b1;
						state <= H_END;
					end
				end
				H_SETUP: if (tick) begin
					sclk <= 1'b0;
					mosi <= tx[7];
					state <= H_LOW;
				end
				H_LOW: if (tick) begin
					sclk <= 1'b1;
					state <= H_HIGH;
				end
				H_HIGH: if (tick) begin
					rx <= {rx[6:0], sync[0]};
					tx <= {tx[6:0], 1'b0};
					if (bitn == 3'h7) begin
						sclk <= ctrl[`CCSP_CTRL_IDLE_HIGH];
						state <= H_GAP;
					end else begin
						bitn <= bitn + 3'h1;
						sclk <= 1'b0;
						mosi <= tx[6];
						state <= H_LOW;
					end
				end
				H_GAP: if (tick) begin
					if (ctrl[`CCSP_CTRL_HOLD]) begin
						state <= H_IDLE;
					end else begin
						csn <= 1'b1;
						state <= H_END;
					end
				end
				H_END: if (tick) begin
					state <= H_IDLE;
				end
			endcase
		end
	end

	assign link.spi_clk = sclk;
	assign link.cs_n = csn;
	assign link.mosi = mosi;
endmodule
`default_nettype wire

// [tb/ccsp_monitor.sv]
// Concurrent checks on the serial link between host and coupler
`default_nettype none
module ccsp_monitor (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic spi_clk,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic miso_oe,
	input wire logic miso_line,
	input wire logic irq_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_q; // Serial clock one cycle back
	logic [5:0] rises; // Clock rises seen in the open frame
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	// Delayed copy for rise detection
	always_ff @(posedge clk_sys_i) begin
		clk_q <= spi_clk;
	end
	// Only rises inside a frame count, so each byte ends on a multiple of eight
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i || cs_n) begin
			rises <= 6'h00;
		end else if (spi_clk && !clk_q) begin
			rises <= rises + 6'h01;
		end
	end
	// No rising clock edge in the spacing after a byte
	sequence s_clk_still;
		!$rose(spi_clk) [*4];
	endsequence
	// Eighth rise of a byte
	sequence s_byte_end;
		$rose(spi_clk) && !cs_n && rises[2:0] == 3'h7;
	endsequence
	a_irq_reset_high: assert property ($fell(sys_rst_i) |-> irq_n)
		else $error("interrupt low right after reset");
	a_cs_idle_quiet: assert property (cs_n [*5] |-> !miso_oe)
		else $error("status line driven with select high");
	a_line_pullup: assert property (!miso_oe |-> miso_line)
		else $error("released status line not high");
	// Status bits move only while the clock is low, so the host samples a settled bit
	a_miso_steady_high: assert property (spi_clk && $past(spi_clk) && miso_oe
		&& $past(miso_oe) |-> $stable(miso_line))
		else $error("status bit moved while clock high");
	a_irq_release_frame: assert property ($rose(irq_n) |-> cs_n && $past(cs_n, 2))
		else $error("interrupt released outside a closed write");
	a_mosi_hold_high: assert property (spi_clk && $past(spi_clk) && !cs_n && $past(!cs_n)
		|-> $stable(mosi))
		else $error("command bit moved while clock high");
	a_cs_fall_still: assert property ($fell(cs_n) |-> $stable(spi_clk) [*3])
		else $error("clock moved right at frame start");
	a_byte_whole: assert property ($rose(cs_n) |-> rises[2:0] == 3'h0 && rises != 6'h00)
		else $error("frame closed on a partial byte");
	a_gap_after_byte: assert property (s_byte_end |=> s_clk_still)
		else $error("byte bursts too close");
	a_oe_after_addr: assert property ($rose(miso_oe) |-> !cs_n && rises[2:0] >= 3'h3)
		else $error("status driven before address decoded");
endmodule
`default_nettype wire

// [tb/ccsp_tb.sv]
// Bench joining host and coupler ends over one link
`include "ccsp_defs.svh"
`default_nettype none
module ccsp_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import ccsp_pkg::*;
	logic clk_sys_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [1:0] addr = 2'h0; // Host register offset
	ccsp_byte_t wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	ccsp_byte_t rdata;
	logic sw = 1'b0; // Presence switch, high when present
	logic fault = 1'b0; // Supply overload
	logic io_lvl = 1'b1; // Card data line
	logic irq_dev_n;
	ccsp_byte_t cmd_reg;
	ccsp_sup_t supply;
	logic present;
	logic upd; // Command update pulse from the coupler
	int updates = 0; // Update pulses seen so far
	logic watch = 1'b0; // Arms the interrupt release tracker
	logic glitch = 1'b0; // Set if interrupt was not low while armed
	int checked = 0;
	int fail_count = 0;
	ccsp_if link_if();
	ccsp_host #(.HALF_DIV(4)) ccsp_host_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
		.link(link_if), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata));
	// Straps give this chip address 010
	ccsp_device ccsp_device_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .link(link_if),
		.card_presence_switch_i(sw), .supply_fault_i(fault), .card_io_level_i(io_lvl),
		.aux_contact_low_i(1'b0), .aux_contact_high_i(1'b1), .irq_n_o(irq_dev_n),
		.host_command_register_o(cmd_reg), .cmd_update_o(upd), .card_supply_output_o(supply),
		.card_present_o(present));
	ccsp_monitor ccsp_monitor_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
		.spi_clk(link_if.spi_clk), .cs_n(link_if.cs_n), .mosi(link_if.mosi),
		.miso_oe(link_if.miso_oe), .miso_line(link_if.miso_line), .irq_n(link_if.irq_n));
	// System clock, 100 ns
	initial begin
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	// Any cycle with the interrupt not low while armed is remembered
	always @(posedge clk_sys_i) begin
		if (watch && link_if.irq_n !== 1'b0) begin
			glitch <= 1'b1;
		end
	end
	// One pulse per applied byte; a stretched pulse would show as extra counts
	always @(posedge clk_sys_i) begin
		if (upd === 1'b1) begin
			updates++;
		end
	end
	task automatic check_v(input string name, input ccsp_byte_t exp, input ccsp_byte_t got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic reg_wr(input logic [1:0] a, input ccsp_byte_t d);
		@(posedge clk_sys_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys_i);
		wr <= 1'b0;
	endtask
	// Read data stand in the cycle after the strobe
	task automatic reg_rd(input logic [1:0] a, output ccsp_byte_t d);
		@(posedge clk_sys_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys_i);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	// One byte out, waits for idle under a bound, then checks what came back
	task automatic send(input ccsp_byte_t b, input ccsp_byte_t exp_rx);
		ccsp_byte_t st;
		int n;
		reg_wr(`CCSP_REG_TX, b);
		st = 8'h01;
		n = 0;
		while (st[0] !== 1'b0 && n < 400) begin
			reg_rd(`CCSP_REG_STATUS, st);
			n++;
		end
		if (n >= 400) begin
			fail_count++;
		end
		reg_rd(`CCSP_REG_RX, st);
		check_v("rx", exp_rx, st);
		wait_cyc(8);
	endtask
	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Watchdog, far beyond the expected run of under two thousand cycles
	initial begin
		#2000000;
		fail_count++;
		wrap_up();
	end
	// Main sequence
	initial begin
		ccsp_byte_t st;
		repeat (3) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		wait_cyc(1);
		check_v("irq", 8'h01, {7'h00, link_if.irq_n});
		@(posedge clk_sys_i);
		sw <= 1'b1;
		wait_cyc(10);
		check_v("irq", 8'h00, {7'h00, link_if.irq_n});
		check_v("irq_pin", 8'h00, {7'h00, irq_dev_n});
		// Every foreign address is ignored, nothing comes back
		for (int a = 0; a < 8; a++) begin
			if (a != 2 && a != 5) begin
				send({a[2:0], 5'h01}, 8'hff);
			end
		end
		check_v("irq", 8'h00, {7'h00, link_if.irq_n});
		check_v("supply", 8'h00, {6'h00, supply});
		check_v("updates", 8'h00, 8'(updates));
		send(8'h41, 8'hfc);
		check_v("irq", 8'h01, {7'h00, link_if.irq_n});
		check_v("supply", 8'h01, {6'h00, supply});
		check_v("cmd", 8'h41, cmd_reg);
		// Extraction: a non-zero write to the shared address does not clear it
		@(posedge clk_sys_i);
		io_lvl <= 1'b0;
		sw <= 1'b0;
		wait_cyc(10);
		check_v("irq", 8'h00, {7'h00, link_if.irq_n});
		send(8'ha2, 8'he5);
		check_v("irq", 8'h00, {7'h00, link_if.irq_n});
		check_v("supply", 8'h02, {6'h00, supply});
		send(8'h40, 8'he6);
		check_v("irq", 8'h01, {7'h00, link_if.irq_n});
		// Overload forces the supply off
		send(8'h43, 8'he0);
		check_v("supply", 8'h03, {6'h00, supply});
		@(posedge clk_sys_i);
		fault <= 1'b1;
		wait_cyc(10);
		check_v("supply", 8'h00, {6'h00, supply});
		check_v("irq", 8'h00, {7'h00, link_if.irq_n});
		@(posedge clk_sys_i);
		fault <= 1'b0;
		reg_rd(`CCSP_REG_STATUS, st);
		check_v("status_irq", 8'h01, {7'h00, st[`CCSP_ST_IRQ]});
		send(8'h40, 8'he4);
		check_v("irq", 8'h01, {7'h00, link_if.irq_n});
		// Insert, pull, reinsert with no acknowledge between
		@(posedge clk_sys_i);
		sw <= 1'b1;
		repeat (10) @(posedge clk_sys_i);
		watch <= 1'b1;
		sw <= 1'b0;
		repeat (10) @(posedge clk_sys_i);
		sw <= 1'b1;
		repeat (10) @(posedge clk_sys_i);
		watch <= 1'b0;
		wait_cyc(1);
		check_v("irq_hold", 8'h00, {7'h00, glitch});
		// Idle-high clock, two bytes in one held frame
		reg_wr(`CCSP_REG_CTRL, 8'h03);
		send(8'h01, 8'hff);
		send(8'h41, 8'hf4);
		reg_wr(`CCSP_REG_CTRL, 8'h02);
		wait_cyc(8);
		check_v("cmd", 8'h41, cmd_reg);
		check_v("supply", 8'h01, {6'h00, supply});
		check_v("irq", 8'h00, {7'h00, link_if.irq_n});
		send(8'h40, 8'hf5);
		check_v("irq", 8'h01, {7'h00, link_if.irq_n});
		check_v("present", 8'h01, {7'h00, present});
		check_v("updates", 8'h07, 8'(updates));
		wrap_up();
	end
endmodule
`default_nettype wire
